// File: isc_core.sv
// Interrupt acceptance and stack sequencing for an 8-bit core.
// Assumes the core issues stack and flag operations as one-cycle starts
// and waits for op_done; interrupt sources are asynchronous pins.
//
// Summary of operation
// - Acceptance pushes status word automatically
// - Accept needs request, enable, disable clear
// - Software break ignores disable and enables
// - Event sets request bit even when disabled
// - Acceptance clears the accepted request bit
// - Latched request accepted once later enabled
// - Software write of zero clears request
// - Enable applies before clear in one write
// - Acceptance sets the interrupt disable flag
// - Clear-disable op lets nested interrupts in
// - Set-disable op masks all maskable sources
// - Call pushes high then low byte
// - Call leaves status word untouched
// - Return loads saved address, not status
// - Interrupt return resumes interrupted program
// - Push and pull of accumulator, status
`timescale 1ns/1ps
module isc_core
   import isc_pkg::*;
#(
   parameter int NUM_SRC = CTL_FLD_W
)(
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              sys_rst,
   // Register port
   input  wire logic [REG_AW-1:0] reg_addr,
   input  wire logic [DATA_W-1:0] reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [DATA_W-1:0] reg_rdata,
   // Interrupt source pins
   input  wire logic [NUM_SRC-1:0] irq_src,
   // Core operation port
   input  wire logic              op_start,
   input  isc_op_type             op_code,
   input  wire logic [PC_W-1:0]   op_pc,
   input  wire logic [DATA_W-1:0] op_acc,
   input  wire logic [PC_W-1:0]   cur_pc,
   output logic                   op_done,
   output logic                   op_busy,
   output logic      [PC_W-1:0]   pc_out,
   output logic      [DATA_W-1:0] acc_out,
   output logic      [DATA_W-1:0] ps_out,
   output logic      [STK_AW-1:0] sp_out,
   // Handler entry report
   output logic                   entry,
   output logic                   entry_brk,
   output logic      [1:0]        entry_src,
   // Interrupt to the system
   output logic                   irq
);

   localparam logic [1:0] STEP_ONE = 2'h1;

   isc_stack_if #(.AW(STK_AW), .DW(DATA_W)) stk ();

   isc_stack_mem #(.AW(STK_AW), .DW(DATA_W)) u_mem (
      .clk     (clk),
      .sys_rst (sys_rst),
      .port    (stk)
   );

   // Pin synchronisers and edge detect
   logic [NUM_SRC-1:0] sync1_q;
   logic [NUM_SRC-1:0] sync2_q;
   logic [NUM_SRC-1:0] sync3_q;
   logic [NUM_SRC-1:0] src_edge;

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         sync1_q <= '0;
         sync2_q <= '0;
         sync3_q <= '0;
      end
      else
      begin
         sync1_q <= irq_src;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
      end
   end

   assign src_edge = sync2_q & ~sync3_q;

   // Register port decode
   logic wr_req;
   logic wr_en;
   logic wr_ctl;
   logic wr_ps;
   logic wr_sp;
   logic wr_ist;
   logic wr_imsk;

   assign wr_req  = reg_wr && (reg_addr == REG_REQ);
   assign wr_en   = reg_wr && (reg_addr == REG_EN);
   assign wr_ctl  = reg_wr && (reg_addr == REG_CTL);
   assign wr_ps   = reg_wr && (reg_addr == REG_PS);
   assign wr_sp   = reg_wr && (reg_addr == REG_SP);
   assign wr_ist  = reg_wr && (reg_addr == REG_IST);
   assign wr_imsk = reg_wr && (reg_addr == REG_IMSK);

   // Sequencer state
   isc_state_type     st_q, st_d;
   isc_op_type        job_q, job_d;
   logic [1:0]        step_q, step_d;
   logic [STK_AW-1:0] sp_q, sp_d;
   logic [DATA_W-1:0] ps_q, ps_d;
   logic [PC_W-1:0]   pc_q, pc_d;
   logic [DATA_W-1:0] acc_q, acc_d;
   logic              done_q, done_d;

   // Request and enable state
   logic [NUM_SRC-1:0] req_q, req_d;
   logic [NUM_SRC-1:0] en_q, en_d;
   logic [NUM_SRC-1:0] eligible;
   logic [NUM_SRC-1:0] take_vec;
   logic [1:0]         take_idx;
   logic               take_any;

   always_comb
   begin
      en_d = en_q;
      req_d = req_q;
      if (wr_en)
      begin
         en_d = reg_wdata[NUM_SRC-1:0];
      end
      if (wr_ctl)
      begin
         en_d = reg_wdata[CTL_EN_LSB +: NUM_SRC];
      end
      if (wr_req)
      begin
         req_d = req_q & reg_wdata[NUM_SRC-1:0];
      end
      if (wr_ctl)
      begin
         req_d = req_q & reg_wdata[CTL_REQ_LSB +: NUM_SRC];
      end
      // New enable meets the old request, so a combined write still takes
      eligible = req_q & en_d & {NUM_SRC{~ps_q[PS_I_BIT]}};
      take_any = (st_q == st_idle) && !op_start && (|eligible);
      take_vec = '0;
      take_idx = 2'h0;
      for (int i = NUM_SRC - 1; i >= 0; i--)
      begin
         if (eligible[i])
         begin
            take_vec = '0;
            take_vec[i] = 1'b1;
            take_idx = i[1:0];
         end
      end
      if (take_any)
      begin
         req_d = req_d & ~take_vec;
      end
      // A new event beats any clear in the same cycle
      req_d = req_d | src_edge;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         req_q <= '0;
         en_q  <= '0;
      end
      else
      begin
         req_q <= req_d;
         en_q  <= en_d;
      end
   end

   // Last step index of each job
   function automatic logic [1:0] last_step(input isc_op_type j);
      case (j)
         irq_entry_op, software_break_op,
         interrupt_return_op:                  last_step = 2'h2;
         subroutine_call_op,
         subroutine_return_op:                 last_step = 2'h1;
         default:                              last_step = 2'h0;
      endcase
   endfunction : last_step

   // Byte pushed at a given step
   function automatic logic [DATA_W-1:0] push_byte(
      input isc_op_type        j,
      input logic [1:0]        s,
      input logic [PC_W-1:0]   pc,
      input logic [DATA_W-1:0] acc,
      input logic [DATA_W-1:0] ps
   );
      logic [DATA_W-1:0] b;
      b = ps;
      b[PS_B_BIT] = (j == software_break_op);
      case (s)
         2'h0:    push_byte = pc[PC_W-1:DATA_W];
         2'h1:    push_byte = pc[DATA_W-1:0];
         default: push_byte = b;
      endcase
      if (j == push_accumulator_op)
      begin
         push_byte = acc;
      end
      if (j == push_status_op)
      begin
         push_byte = ps;
      end
   endfunction : push_byte

   logic              mem_we;
   logic              mem_re;
   logic [STK_AW-1:0] mem_addr;
   logic [DATA_W-1:0] mem_wdata;
   logic              ev_take;
   logic              ev_brk;
   logic              ev_ret;

   always_comb
   begin
      st_d = st_q;
      job_d = job_q;
      step_d = step_q;
      sp_d = sp_q;
      ps_d = ps_q;
      pc_d = pc_q;
      acc_d = acc_q;
      done_d = 1'b0;
      mem_we = 1'b0;
      mem_re = 1'b0;
      mem_addr = sp_q;
      mem_wdata = BYTE_RST;
      ev_take = 1'b0;
      ev_brk = 1'b0;
      ev_ret = 1'b0;
      case (st_q)
         st_idle:
         begin
            if (wr_ps)
            begin
               ps_d = reg_wdata;
            end
            if (wr_sp)
            begin
               sp_d = reg_wdata;
            end
            step_d = 2'h0;
            if (op_start)
            begin
               job_d = op_code;
               pc_d = op_pc;
               acc_d = op_acc;
               case (op_code)
                  set_irq_disable_op:
                  begin
                     ps_d[PS_I_BIT] = 1'b1;
                     done_d = 1'b1;
                  end
                  clear_irq_disable_op:
                  begin
                     ps_d[PS_I_BIT] = 1'b0;
                     done_d = 1'b1;
                  end
                  subroutine_call_op, push_accumulator_op,
                  push_status_op:
                  begin
                     st_d = st_push;
                  end
                  software_break_op:
                  begin
                     st_d = st_push;
                     ev_brk = 1'b1;
                  end
                  subroutine_return_op, interrupt_return_op,
                  pull_accumulator_op, pull_status_op:
                  begin
                     st_d = st_pull;
                  end
                  default:
                  begin
                     done_d = 1'b1;
                  end
               endcase
            end
            else if (take_any)
            begin
               job_d = irq_entry_op;
               pc_d = cur_pc;
               st_d = st_push;
               ev_take = 1'b1;
            end
         end
         st_push:
         begin
            mem_we = 1'b1;
            // High byte first, status last on entry
            mem_wdata = push_byte(job_q, step_q, pc_q, acc_q, ps_q);
            sp_d = sp_q - 8'h01;
            step_d = step_q + STEP_ONE;
            if (step_q == last_step(job_q))
            begin
               st_d = st_idle;
               done_d = 1'b1;
               if ((job_q == irq_entry_op) || (job_q == software_break_op))
               begin
                  ps_d[PS_I_BIT] = 1'b1;
               end
            end
         end
         st_pull:
         begin
            mem_re = 1'b1;
            mem_addr = sp_q + 8'h01;
            sp_d = sp_q + 8'h01;
            st_d = st_capt;
         end
         st_capt:
         begin
            case (job_q)
               interrupt_return_op:
               begin
                  // Reverse of entry: status, then low, then high
                  case (step_q)
                     2'h0:    ps_d = stk.rdata;
                     2'h1:    pc_d[DATA_W-1:0] = stk.rdata;
                     default: pc_d[PC_W-1:DATA_W] = stk.rdata;
                  endcase
               end
               subroutine_return_op:
               begin
                  // Status word is left alone on this return
                  if (step_q == 2'h0)
                  begin
                     pc_d[DATA_W-1:0] = stk.rdata;
                  end
                  else
                  begin
                     pc_d[PC_W-1:DATA_W] = stk.rdata;
                  end
               end
               pull_accumulator_op: acc_d = stk.rdata;
               pull_status_op:      ps_d = stk.rdata;
               default:             acc_d = acc_q;
            endcase
            if (step_q == last_step(job_q))
            begin
               st_d = st_idle;
               done_d = 1'b1;
               ev_ret = (job_q == interrupt_return_op);
            end
            else
            begin
               step_d = step_q + STEP_ONE;
               st_d = st_pull;
            end
         end
         default:
         begin
            st_d = st_idle;
         end
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         st_q   <= st_idle;
         job_q  <= no_op;
         step_q <= 2'h0;
         sp_q   <= SP_RST;
         ps_q   <= PS_RST;
         pc_q   <= PC_RST;
         acc_q  <= BYTE_RST;
         done_q <= 1'b0;
      end
      else
      begin
         st_q   <= st_d;
         job_q  <= job_d;
         step_q <= step_d;
         sp_q   <= sp_d;
         ps_q   <= ps_d;
         pc_q   <= pc_d;
         acc_q  <= acc_d;
         done_q <= done_d;
      end
   end

   assign stk.we    = mem_we;
   assign stk.re    = mem_re;
   assign stk.addr  = mem_addr;
   assign stk.wdata = mem_wdata;

   // Handler entry report, registered
   logic       entry_q, entry_d;
   logic       ebrk_q, ebrk_d;
   logic [1:0] esrc_q, esrc_d;

   always_comb
   begin
      entry_d = ev_take || ev_brk;
      ebrk_d = ev_brk;
      esrc_d = ev_take ? take_idx : esrc_q;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         entry_q <= 1'b0;
         ebrk_q  <= 1'b0;
         esrc_q  <= 2'h0;
      end
      else
      begin
         entry_q <= entry_d;
         ebrk_q  <= ebrk_d;
         esrc_q  <= esrc_d;
      end
   end

   // Sticky event status, write one to clear; set wins
   logic [EV_W-1:0]   ist_q, ist_d;
   logic [EV_W-1:0]   imsk_q, imsk_d;
   logic [EV_W-1:0]   ev_vec;
   logic [DATA_W-1:0] rdata_q, rdata_d;

   always_comb
   begin
      ev_vec = '0;
      ev_vec[EV_TAKE] = ev_take;
      ev_vec[EV_BRK] = ev_brk;
      ev_vec[EV_RET] = ev_ret;
      ist_d = ist_q;
      if (wr_ist)
      begin
         ist_d = ist_q & ~reg_wdata[EV_W-1:0];
      end
      ist_d = ist_d | ev_vec;
      imsk_d = wr_imsk ? reg_wdata[EV_W-1:0] : imsk_q;
      rdata_d = BYTE_RST;
      if (reg_rd)
      begin
         case (reg_addr)
            REG_REQ:  rdata_d[NUM_SRC-1:0] = req_q;
            REG_EN:   rdata_d[NUM_SRC-1:0] = en_q;
            REG_CTL:
            begin
               rdata_d[CTL_EN_LSB +: NUM_SRC] = en_q;
               rdata_d[CTL_REQ_LSB +: NUM_SRC] = req_q;
            end
            REG_PS:   rdata_d = ps_q;
            REG_SP:   rdata_d = sp_q;
            REG_IST:  rdata_d[EV_W-1:0] = ist_q;
            REG_IMSK: rdata_d[EV_W-1:0] = imsk_q;
            default:  rdata_d = BYTE_RST;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         ist_q   <= '0;
         imsk_q  <= '0;
         rdata_q <= BYTE_RST;
      end
      else
      begin
         ist_q   <= ist_d;
         imsk_q  <= imsk_d;
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata = rdata_q;
   assign irq       = |(ist_q & imsk_q);
   assign op_done   = done_q;
   assign op_busy   = (st_q != st_idle);
   assign pc_out    = pc_q;
   assign acc_out   = acc_q;
   assign ps_out    = ps_q;
   assign sp_out    = sp_q;
   assign entry     = entry_q;
   assign entry_brk = ebrk_q;
   assign entry_src = esrc_q;

endmodule : isc_core

// File: isc_pkg.sv
// Constants and types for the interrupt and stack control unit.
// Assumes an 8-bit core with a 16-bit program counter and a byte stack.
package isc_pkg;

   localparam int DATA_W = 8;
   localparam int PC_W   = 16;
   localparam int REG_AW = 3;
   localparam int STK_AW = 8;

   // Register map of the plain register port
   localparam logic [REG_AW-1:0] REG_REQ  = 3'h0;
   localparam logic [REG_AW-1:0] REG_EN   = 3'h1;
   localparam logic [REG_AW-1:0] REG_CTL  = 3'h2;
   localparam logic [REG_AW-1:0] REG_PS   = 3'h3;
   localparam logic [REG_AW-1:0] REG_SP   = 3'h4;
   localparam logic [REG_AW-1:0] REG_IST  = 3'h5;
   localparam logic [REG_AW-1:0] REG_IMSK = 3'h6;

   // Combined register: enables low, request keep-mask high
   localparam int CTL_EN_LSB  = 0;
   localparam int CTL_REQ_LSB = 4;
   localparam int CTL_FLD_W   = 4;

   // Status word fields
   localparam int PS_I_BIT = 2;
   localparam int PS_B_BIT = 4;

   // Event status bits
   localparam int EV_TAKE = 0;
   localparam int EV_BRK  = 1;
   localparam int EV_RET  = 2;
   localparam int EV_W    = 3;

   // Reset values
   localparam logic [DATA_W-1:0] PS_RST   = 8'h04;
   localparam logic [STK_AW-1:0] SP_RST   = 8'hff;
   localparam logic [DATA_W-1:0] BYTE_RST = 8'h00;
   localparam logic [PC_W-1:0]   PC_RST   = 16'h0000;

   typedef enum logic [3:0] {
      no_op,
      set_irq_disable_op,
      clear_irq_disable_op,
      subroutine_call_op,
      subroutine_return_op,
      interrupt_return_op,
      software_break_op,
      push_accumulator_op,
      pull_accumulator_op,
      push_status_op,
      pull_status_op,
      irq_entry_op
   } isc_op_type;

   typedef enum {
      st_idle,
      st_push,
      st_pull,
      st_capt
   } isc_state_type;

endpackage : isc_pkg

// File: isc_stack_if.sv
// Link between the stack sequencer and the stack memory.
// Read data return one cycle after the read strobe.
`timescale 1ns/1ps
interface isc_stack_if #(
   parameter int AW = 8,
   parameter int DW = 8
);
   logic          we;
   logic          re;
   logic [AW-1:0] addr;
   logic [DW-1:0] wdata;
   logic [DW-1:0] rdata;

   modport ctrl  (output we, re, addr, wdata, input rdata);
   modport store (input we, re, addr, wdata, output rdata);
endinterface : isc_stack_if

// File: isc_stack_mem.sv
// Stack memory with registered read data.
// Assumes one access per cycle from the stack sequencer.
`timescale 1ns/1ps
module isc_stack_mem
   import isc_pkg::*;
#(
   parameter int AW = STK_AW,
   parameter int DW = DATA_W
)(
   // Clock and reset
   input wire logic  clk,
   input wire logic  sys_rst,
   // Sequencer side
   isc_stack_if.store port
);

   logic [DW-1:0] mem [0:(1<<AW)-1];
   logic [DW-1:0] rdata_q;

   always_ff @(posedge clk)
   begin
      if (port.we)
      begin
         mem[port.addr] <= port.wdata;
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         rdata_q <= '0;
      end
      else if (port.re)
      begin
         rdata_q <= mem[port.addr];
      end
   end

   assign port.rdata = rdata_q;

endmodule : isc_stack_mem

// File: isc_src_model.sv
// Pin model of the peripheral interrupt sources.
// Assumes the bench asks for one event by a one-cycle fire bit.
`timescale 1ns/1ps
module isc_src_model
#(
   parameter int NSRC = 4,
   parameter int HOLD = 4
)(
   // Clock and reset
   input wire logic            clk,
   input wire logic            sys_rst,
   // Bench control
   input wire logic [NSRC-1:0] fire,
   // Source pins
   output logic     [NSRC-1:0] irq_src
);
   int cnt [NSRC];

   // Pulse outlasts the core's two-flop synchroniser
   always_ff @(posedge clk)
   begin
      for (int i = 0; i < NSRC; i++)
      begin
         if (sys_rst)
            cnt[i] <= 0;
         else if (fire[i])
            cnt[i] <= HOLD;
         else if (cnt[i] != 0)
            cnt[i] <= cnt[i] - 1;
      end
   end

   always_comb
   begin
      for (int i = 0; i < NSRC; i++)
         irq_src[i] = (cnt[i] != 0);
   end
endmodule : isc_src_model

// File: isc_core_sva.sv
// Port checker for the interrupt and stack control core.
// Assumes one-cycle op_done and entry pulses.
`timescale 1ns/1ps
module isc_core_sva
   import isc_pkg::*;
(
   // Clock and reset
   input wire logic              clk,
   input wire logic              sys_rst,
   // Operation port
   input wire logic              op_start,
   input isc_op_type             op_code,
   input wire logic              op_busy,
   input wire logic              op_done,
   input wire logic [DATA_W-1:0] ps_out,
   input wire logic [STK_AW-1:0] sp_out,
   // Handler entry
   input wire logic              entry,
   input wire logic              entry_brk
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   logic go;
   logic ient;
   assign go = op_start && !op_busy;
   assign ient = entry && !entry_brk;

   chk_entry_push: assert property (
      ient |-> ##3 (op_done && sp_out == $past(sp_out, 4) - 8'h03))
      else $error("entry push count wrong");
   chk_accept_gate: assert property (
      ient |-> !$past(ps_out[PS_I_BIT]))
      else $error("entry while disabled");
   chk_entry_iset: assert property (
      ient |-> ##3 ps_out[PS_I_BIT] ##1 ps_out[PS_I_BIT])
      else $error("disable flag not set on entry");
   chk_brk_entry: assert property (
      go && op_code == software_break_op |-> ##[1:2] (entry && entry_brk))
      else $error("break gave no entry");
   chk_call_push: assert property (
      go && op_code == subroutine_call_op
      |-> ##3 (op_done && sp_out == $past(sp_out, 3) - 8'h02))
      else $error("call push count wrong");
   chk_call_busy: assert property (
      go && op_code == subroutine_call_op |=> op_busy[*2] ##1 !op_busy)
      else $error("call busy window wrong");
   chk_push_acc: assert property (
      go && op_code == push_accumulator_op
      |-> ##2 (op_done && sp_out == $past(sp_out, 2) - 8'h01))
      else $error("accumulator push wrong");
   chk_call_ps: assert property (
      go && op_code == subroutine_call_op |=> $stable(ps_out)[*3])
      else $error("call changed status");
   chk_ret_pull: assert property (
      go && op_code == subroutine_return_op
      |-> ##5 (op_done && sp_out == $past(sp_out, 5) + 8'h02))
      else $error("return pull count wrong");
   chk_rti_pull: assert property (
      go && op_code == interrupt_return_op
      |-> ##7 (op_done && sp_out == $past(sp_out, 7) + 8'h03))
      else $error("interrupt return pull wrong");
   chk_sei_flag: assert property (
      go && op_code == set_irq_disable_op |=> op_done && ps_out[PS_I_BIT])
      else $error("set disable failed");
   chk_cli_flag: assert property (
      go && op_code == clear_irq_disable_op
      |=> op_done && !ps_out[PS_I_BIT])
      else $error("clear disable failed");
endmodule : isc_core_sva

bind isc_core isc_core_sva u_sva (
   .clk, .sys_rst, .op_start, .op_code, .op_busy, .op_done,
   .ps_out, .sp_out, .entry, .entry_brk
);

// File: interrupt_and_subroutine_stack_control_tb.sv
// Self-checking bench for the interrupt and stack control core.
// Sources come from the pin model; registers and ops from tasks.
`timescale 1ns/1ps
module interrupt_and_subroutine_stack_control_tb
   import isc_pkg::*;
;
   logic              clk = 1'b0;
   logic              sys_rst = 1'b1;
   logic [REG_AW-1:0] reg_addr = '0;
   logic [DATA_W-1:0] reg_wdata = '0;
   logic              reg_wr = 1'b0;
   logic              reg_rd = 1'b0;
   logic              op_start = 1'b0;
   isc_op_type        op_code = no_op;
   logic [PC_W-1:0]   op_pc = '0;
   logic [DATA_W-1:0] op_acc = '0;
   logic [PC_W-1:0]   cur_pc = '0;
   logic [3:0]        src_fire = '0;
   logic [DATA_W-1:0] reg_rdata, acc_out, ps_out;
   logic [STK_AW-1:0] sp_out;
   logic [PC_W-1:0]   pc_out;
   logic [3:0]        irq_src;
   logic [1:0]        entry_src;
   logic              op_done, op_busy, entry, entry_brk, irq;
   logic              last_brk = 1'b0;
   int                n_entry = 0;
   int                error_cnt = 0;
   int                compares = 0;

   always #10 clk = ~clk;

   isc_core u_dut (
      .clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .irq_src, .op_start, .op_code, .op_pc, .op_acc,
      .cur_pc, .op_done, .op_busy, .pc_out, .acc_out, .ps_out,
      .sp_out, .entry, .entry_brk, .entry_src, .irq
   );

   isc_src_model u_src (.clk, .sys_rst, .fire(src_fire), .irq_src);

   // Mid-cycle sampling keeps the count clear of edge races
   always @(negedge clk)
   begin
      if (entry === 1'b1)
      begin
         n_entry++;
         last_brk = entry_brk;
      end
   end

   task automatic summarize;
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : summarize

   task automatic cmp(input string n, input logic [15:0] g, e);
      compares++;
      if (g !== e)
      begin
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
         error_cnt++;
      end
   endtask : cmp

   // Bounded wait for entry (s=1) or op_done (s=0)
   task automatic wt(input bit s);
      int k;
      for (k = 0; k < 40; k++)
      begin
         #1;
         if ((s ? entry : op_done) === 1'b1)
            break;
         @(posedge clk);
      end
      if (k == 40)
      begin
         cmp("wait", 16'h0, 16'h1);
         summarize();
      end
   endtask : wt

   task automatic rd(input logic [2:0] a, input logic [7:0] e,
                     input string n);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      cmp(n, 16'(reg_rdata), 16'(e));
   endtask : rd

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic op(input isc_op_type c, input logic [15:0] p = 16'h0,
                     input logic [7:0] a = 8'h0);
      @(posedge clk);
      op_start <= 1'b1;
      op_code <= c;
      op_pc <= p;
      op_acc <= a;
      @(posedge clk);
      op_start <= 1'b0;
      wt(1'b0);
   endtask : op

   task automatic quiet;
      int n0;
      n0 = n_entry;
      repeat (8) @(posedge clk);
      cmp("entries", 16'(n_entry), 16'(n0));
   endtask : quiet

   task automatic pulse(input int s);
      @(posedge clk);
      src_fire <= 4'(1 << s);
      @(posedge clk);
      src_fire <= 4'h0;
      quiet();
   endtask : pulse

   initial
   begin
      logic [7:0] p;
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      rd(REG_PS, PS_RST, "ps");
      rd(3'h7, 8'h00, "unmapped");
      pulse(1);
      rd(REG_REQ, 8'h02, "req");
      wr(REG_EN, 8'h02);
      quiet();
      cur_pc <= 16'h4321;
      op(clear_irq_disable_op);
      wt(1'b1);
      cmp("src", 16'(entry_src), 16'h1);
      wt(1'b0);
      cmp("ps", 16'(ps_out), 16'h04);
      cmp("sp", 16'(sp_out), 16'hfc);
      rd(REG_REQ, 8'h00, "req");
      rd(REG_IST, 8'h01, "ist");
      wr(REG_IMSK, 8'h01);
      #1 cmp("irq", 16'(irq), 16'h1);
      wr(REG_IST, 8'h01);
      #1 cmp("irq", 16'(irq), 16'h0);
      wr(REG_EN, 8'h06);
      pulse(2);
      cur_pc <= 16'h5678;
      op(clear_irq_disable_op);
      wt(1'b1);
      cmp("src", 16'(entry_src), 16'h2);
      wt(1'b0);
      op(interrupt_return_op);
      cmp("pc", pc_out, 16'h5678);
      cmp("ps", 16'(ps_out), 16'h00);
      op(interrupt_return_op);
      cmp("pc", pc_out, 16'h4321);
      cmp("sp", 16'(sp_out), 16'hff);
      wr(REG_CTL, 8'hf0);
      pulse(3);
      rd(REG_REQ, 8'h08, "req");
      wr(REG_REQ, 8'h00);
      rd(REG_REQ, 8'h00, "req");
      wr(REG_EN, 8'h08);
      quiet();
      wr(REG_EN, 8'h00);
      pulse(3);
      wr(REG_CTL, 8'h08);
      wt(1'b1);
      cmp("src", 16'(entry_src), 16'h3);
      wt(1'b0);
      rd(REG_REQ, 8'h00, "req");
      op(interrupt_return_op);
      op(set_irq_disable_op);
      cmp("ps", 16'(ps_out), 16'h04);
      pulse(3);
      op(software_break_op, 16'h2468);
      cmp("brk", 16'(last_brk), 16'h1);
      cmp("sp", 16'(sp_out), 16'hfc);
      wr(REG_CTL, 8'h00);
      op(interrupt_return_op);
      cmp("pc", pc_out, 16'h2468);
      cmp("i", 16'(ps_out[PS_I_BIT]), 16'h1);
      p = ps_out;
      op(subroutine_call_op, 16'h1234);
      cmp("sp", 16'(sp_out), 16'hfd);
      cmp("ps", 16'(ps_out), 16'(p));
      op(pull_accumulator_op);
      cmp("acc", 16'(acc_out), 16'h34);
      op(pull_accumulator_op);
      cmp("acc", 16'(acc_out), 16'h12);
      op(subroutine_call_op, 16'h1234);
      op(subroutine_return_op);
      cmp("pc", pc_out, 16'h1234);
      cmp("ps", 16'(ps_out), 16'(p));
      op(push_accumulator_op, 16'h0, 8'h5a);
      op(push_status_op);
      wr(REG_PS, 8'h00);
      op(pull_status_op);
      cmp("ps", 16'(ps_out), 16'(p));
      op(pull_accumulator_op);
      cmp("acc", 16'(acc_out), 16'h5a);
      cmp("sp", 16'(sp_out), 16'hff);
      summarize();
   end
endmodule : interrupt_and_subroutine_stack_control_tb
